// File: hw/ssp_byte_buf.sv
// Single-byte receive/transmit buffer with registered read data
`timescale 1ns/1ps
module ssp_byte_buf #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Write port
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  // Read data
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem_reg;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_reg <= '0;
    end else if (wr_en) begin
      mem_reg <= wr_data;
    end
  end

  assign rd_data = mem_reg;
endmodule

// File: hw/ssp_defines.svh
// Constants for the serial port slave: modes, codes and bits per byte
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH
`define SSP_MODE_SLV7 4'h6
`define SSP_MODE_SLV10 4'h7
`define SSP_MODE_SLV7_SP 4'he
`define SSP_MODE_SLV10_SP 4'hf
`define SSP_MODE_MASTER 4'h8
`define SSP_MODE_FW_MASTER 4'hb
`define SSP_TEN_BIT_HDR 5'h1e
`define SSP_BITS_PER_BYTE 4'h8
`endif

// File: hw/ssp_i2c_slave.sv
// I2C slave side of the synchronous serial port
//
// Operation
// - Port inactive until port enable set
// - Four-bit mode select chooses I2C mode
// - Decode 0110/0111/1110/1111 slave, others not slave
// - Pins driven only as open-drain
// - Flag address match; start/stop optionally
// - Auto acknowledge and load buffer
// - Full or overflow: no ack, flag still
// - Buffer read clears full; overflow software-cleared
// - Wait start, shift 8 bits on rise
// - Compare bits 7:1 at eighth fall; all 8 bits for 10-bit low byte
// - Match: load, full, ack, flag ninth
// - 10-bit address bytes set update flag
// - Resent high byte skips update flag
// - Write address: clear rw, ack low
// - One flag per received data byte
// - Read address: set rw, hold clock
// - Buffer write loads shifter; shift on fall
// - Latch master ack ninth rise; nack ends
// - Transmit flag at ninth falling edge
// - Stretch on transmit; receive if enabled
// - 7-bit receive stretches if still full
// - Clock release settable any time
// - Release one frees clock unless 10-bit update flag set, zero holds
`timescale 1ns/1ps
`include "ssp_defines.svh"
module ssp_i2c_slave
  import ssp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Control
  input wire logic port_enable,
  input wire logic [3:0] mode_select,
  input wire logic stretch_enable,
  input wire logic pins_are_inputs,
  input wire logic [7:0] slave_address,
  input wire logic slave_address_wr,
  input wire logic clock_release_set,
  input wire logic overflow_clear,
  input wire logic irq_flag_clear,
  // Data buffer access
  input wire logic tx_wr,
  input wire logic [7:0] tx_data,
  input wire logic rx_rd,
  output logic [7:0] data_buffer,
  // Status
  output logic buffer_full,
  output logic receive_overflow,
  output logic update_address,
  output logic read_write,
  output logic data_address,
  output logic start_seen,
  output logic stop_seen,
  output logic clock_release,
  output logic port_irq_flag,
  // I2C pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe
);
  logic [1:0] scl_sync_reg, sda_sync_reg;
  logic scl_q_reg, sda_q_reg;
  ssp_state_type state_reg, state_next;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] buf_rd;
  logic buf_wr;
  logic [7:0] buf_wdata;
  logic full_reg, ovf_reg, ua_reg, rw_reg, da_reg;
  logic start_reg, stop_reg, ckp_reg, irq_reg;
  logic ack_ok_reg, is_addr_reg, ten_second_reg, ten_hi_ok_reg;
  logic sda_low_reg, scl_hold_reg, scl_oe_reg, sda_oe_reg;
  logic nack_pend_reg;

  // Mode decode
  wire slave_mode = (mode_select == `SSP_MODE_SLV7) ||
                    (mode_select == `SSP_MODE_SLV10) ||
                    (mode_select == `SSP_MODE_SLV7_SP) ||
                    (mode_select == `SSP_MODE_SLV10_SP);
  wire ten_bit = mode_select[0];
  wire sp_irq = mode_select[3];
  wire active = port_enable && slave_mode;

  // Bus events from synchronised pins
  wire scl_s = scl_sync_reg[1];
  wire sda_s = sda_sync_reg[1];
  wire scl_rise = scl_s && !scl_q_reg;
  wire scl_fall = !scl_s && scl_q_reg;
  wire start_ev = active && scl_s && scl_q_reg && sda_q_reg && !sda_s;
  wire stop_ev = active && scl_s && scl_q_reg && !sda_q_reg && sda_s;
  wire [7:0] shift_in = {shift_reg[6:0], sda_s};

  // Address match at eighth fall, using the completed byte
  wire hdr_byte = shift_reg[7:3] == `SSP_TEN_BIT_HDR;
  wire match7 = shift_reg[7:1] == slave_address[7:1];
  wire match10_hi = hdr_byte && (shift_reg[2:1] == slave_address[2:1]);
  wire match10_lo = shift_reg == slave_address;
  // Low byte only between the two address bytes; re-sent high byte after
  wire addr_match = !ten_bit ? match7 :
                    ((ten_second_reg && !ten_hi_ok_reg) ? match10_lo :
                     match10_hi);
  wire blocked = full_reg || ovf_reg;
  wire eighth_fall = scl_fall && (bit_cnt_reg == `SSP_BITS_PER_BYTE);
  wire ninth_fall = scl_fall && (state_reg == SSP_ACK);
  wire read_addr = shift_reg[0] && (!ten_bit || ten_hi_ok_reg);

  assign buf_wr = tx_wr || (eighth_fall && !blocked &&
                  (state_reg == SSP_RX || addr_match));
  assign buf_wdata = tx_wr ? tx_data : shift_reg;

  ssp_byte_buf #(.WIDTH(8)) u_buf (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .wr_en(buf_wr),
    .wr_data(buf_wdata),
    .rd_data(buf_rd)
  );

  // Pin synchronisers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_q_reg <= 1'h1;
      sda_q_reg <= 1'h1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_q_reg <= scl_s;
      sda_q_reg <= sda_s;
    end
  end

  // Sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SSP_IDLE: begin
        if (start_ev) begin
          state_next = SSP_ADDR;
        end
      end
      SSP_ADDR, SSP_RX: begin
        if (eighth_fall) begin
          if (state_reg == SSP_RX || addr_match) begin
            state_next = SSP_ACK;
          end else begin
            state_next = SSP_IDLE;
          end
        end
      end
      SSP_ACK: begin
        if (ninth_fall) begin
          if (!ack_ok_reg) begin
            state_next = SSP_IDLE;
          end else if (rw_reg) begin
            state_next = SSP_TX;
          end else if (is_addr_reg && ten_bit && !ten_hi_ok_reg) begin
            state_next = SSP_ADDR;
          end else begin
            state_next = SSP_RX;
          end
        end
      end
      SSP_TX: begin
        if (eighth_fall) begin
          state_next = SSP_MACK;
        end
      end
      SSP_MACK: begin
        if (scl_rise) begin
          state_next = sda_s ? SSP_IDLE : SSP_MACK;
        end else if (scl_fall) begin
          state_next = SSP_TX;
        end
      end
      default: state_next = SSP_IDLE;
    endcase
    if (!active || stop_ev) begin
      state_next = SSP_IDLE;
    end else if (start_ev) begin
      state_next = SSP_ADDR;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= SSP_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      if (start_ev || ninth_fall || !active) begin
        bit_cnt_reg <= 4'h0;
      end else if (scl_rise && bit_cnt_reg < `SSP_BITS_PER_BYTE) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end else if (state_reg == SSP_MACK && scl_fall) begin
        bit_cnt_reg <= 4'h0;
      end
      if (tx_wr) begin
        shift_reg <= tx_data;
      end else if (state_reg == SSP_TX && scl_fall) begin
        shift_reg <= {shift_reg[6:0], 1'h0};
      end else if (scl_rise && state_reg != SSP_TX &&
                   state_reg != SSP_MACK) begin
        shift_reg <= shift_in;
      end
    end
  end

  // Status flags; hardware set wins over software clear
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      full_reg <= 1'h0;
      ovf_reg <= 1'h0;
      ua_reg <= 1'h0;
      rw_reg <= 1'h0;
      da_reg <= 1'h0;
      start_reg <= 1'h0;
      stop_reg <= 1'h0;
      ckp_reg <= 1'h1;
      irq_reg <= 1'h0;
      ack_ok_reg <= 1'h0;
      is_addr_reg <= 1'h0;
      ten_second_reg <= 1'h0;
      ten_hi_ok_reg <= 1'h0;
      nack_pend_reg <= 1'h0;
    end else if (!port_enable) begin
      start_reg <= 1'h0;
      stop_reg <= 1'h0;
      ckp_reg <= 1'h1;
      ten_second_reg <= 1'h0;
      ten_hi_ok_reg <= 1'h0;
    end else begin
      if (buf_wr) begin
        full_reg <= 1'h1;
      end else if (rx_rd) begin
        full_reg <= 1'h0;
      end
      if (eighth_fall && blocked && state_reg == SSP_RX) begin
        ovf_reg <= 1'h1;
      end else if (overflow_clear) begin
        ovf_reg <= 1'h0;
      end
      if (start_ev) begin
        start_reg <= 1'h1;
        stop_reg <= 1'h0;
      end else if (stop_ev) begin
        stop_reg <= 1'h1;
        start_reg <= 1'h0;
      end
      if (start_ev && state_reg == SSP_IDLE) begin
        ten_second_reg <= 1'h0;
        ten_hi_ok_reg <= 1'h0;
      end
      if (eighth_fall && state_reg == SSP_ADDR && addr_match) begin
        is_addr_reg <= 1'h1;
        ack_ok_reg <= !blocked;
        da_reg <= 1'h0;
        rw_reg <= read_addr;
        if (ten_bit && !ten_hi_ok_reg) begin
          ua_reg <= 1'h1;
          if (!ten_second_reg) begin
            ten_second_reg <= 1'h1;
          end else begin
            ten_hi_ok_reg <= 1'h1;
          end
        end
      end else if (eighth_fall && state_reg == SSP_RX) begin
        is_addr_reg <= 1'h0;
        ack_ok_reg <= !blocked;
        da_reg <= 1'h1;
      end else if (slave_address_wr) begin
        ua_reg <= 1'h0;
      end
      if (state_reg == SSP_MACK && scl_rise && sda_s) begin
        rw_reg <= 1'h0;
        da_reg <= 1'h0;
        ua_reg <= 1'h0;
      end else if (state_reg == SSP_MACK && scl_fall) begin
        da_reg <= 1'h1;
      end
      // Refused byte still flags at the ninth fall
      if (state_reg == SSP_MACK && scl_rise && sda_s) begin
        nack_pend_reg <= 1'h1;
      end else if (scl_fall || start_ev) begin
        nack_pend_reg <= 1'h0;
      end
      if ((ninth_fall && rw_reg && ack_ok_reg) ||
          (state_reg == SSP_MACK && scl_fall)) begin
        ckp_reg <= 1'h0;
      end else if (ninth_fall && stretch_enable && !is_addr_reg &&
                   !ten_bit && full_reg) begin
        ckp_reg <= 1'h0;
      end else if (ninth_fall && stretch_enable && !is_addr_reg &&
                   ten_bit && full_reg) begin
        ckp_reg <= 1'h0;
      end else if (clock_release_set) begin
        ckp_reg <= 1'h1;
      end
      // Match in ack slot, or every received data byte, or each tx byte
      if (ninth_fall && (is_addr_reg || !rw_reg)) begin
        irq_reg <= 1'h1;
      end else if ((state_reg == SSP_MACK || nack_pend_reg) && scl_fall) begin
        irq_reg <= 1'h1;
      end else if (sp_irq && (start_ev || stop_ev)) begin
        irq_reg <= 1'h1;
      end else if (irq_flag_clear) begin
        irq_reg <= 1'h0;
      end
    end
  end

  // Pin drive: only ever pull low
  wire ack_slot = state_reg == SSP_ACK && ack_ok_reg;
  wire tx_low = (state_reg == SSP_TX) && !shift_reg[7];
  wire ua_hold = ten_bit && ua_reg && state_reg != SSP_ACK;
  wire hold_clk = (!ckp_reg || ua_hold) && !scl_s; // Only once low

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_low_reg <= 1'h0;
      scl_hold_reg <= 1'h0;
      scl_oe_reg <= 1'h0;
      sda_oe_reg <= 1'h0;
    end else begin
      sda_low_reg <= active && pins_are_inputs &&
                     (ack_slot || tx_low);
      scl_hold_reg <= active && pins_are_inputs &&
                      (hold_clk || (scl_hold_reg && !ckp_reg) ||
                       (scl_hold_reg && ua_hold));
      sda_oe_reg <= active && pins_are_inputs &&
                    (ack_slot || tx_low);
      scl_oe_reg <= active && pins_are_inputs &&
                    (hold_clk || (scl_hold_reg && (!ckp_reg || ua_hold)));
    end
  end

  // Registered outputs
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_buffer <= 8'h00;
      scl_out <= 1'h0;
      sda_out <= 1'h0;
      scl_oe <= 1'h0;
      sda_oe <= 1'h0;
    end else begin
      data_buffer <= buf_rd;
      scl_out <= 1'h0;
      sda_out <= 1'h0;
      scl_oe <= scl_oe_reg;
      sda_oe <= sda_oe_reg;
    end
  end

  assign buffer_full = full_reg;
  assign receive_overflow = ovf_reg;
  assign update_address = ua_reg;
  assign read_write = rw_reg;
  assign data_address = da_reg;
  assign start_seen = start_reg;
  assign stop_seen = stop_reg;
  assign clock_release = ckp_reg;
  assign port_irq_flag = irq_reg;
endmodule

// File: hw/ssp_pkg.sv
// Types for the serial port slave
package ssp_pkg;
  typedef enum logic [5:0] {
    SSP_IDLE = 6'h01,
    SSP_ADDR = 6'h02,
    SSP_ACK = 6'h04,
    SSP_RX = 6'h08,
    SSP_TX = 6'h10,
    SSP_MACK = 6'h20
  } ssp_state_type;
endpackage

// File: testbench/ssp_i2c_slave_assertions.sv
// Concurrent checks on the serial port slave pins and flags
`timescale 1ns/1ps
module ssp_i2c_slave_assertions (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Control
  input wire logic port_enable,
  input wire logic pins_are_inputs,
  input wire logic rx_rd,
  input wire logic tx_wr,
  input wire logic clock_release_set,
  input wire logic overflow_clear,
  // Status
  input wire logic buffer_full,
  input wire logic receive_overflow,
  input wire logic update_address,
  input wire logic clock_release,
  // Pins
  input wire logic scl_out,
  input wire logic sda_out,
  input wire logic scl_oe,
  input wire logic sda_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  property p_idle_pins;
    (!(port_enable && pins_are_inputs)) [*3] |-> !scl_oe && !sda_oe;
  endproperty
  a_idle_pins: assert property (p_idle_pins)
    else $error("pin pulled while port off");
  property p_open_drain;
    1'b1 |-> scl_out == 1'b0 && sda_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("pin driven high");
  property p_rd_clears;
    rx_rd && !tx_wr |=> !buffer_full;
  endproperty
  a_rd_clears: assert property (p_rd_clears)
    else $error("full kept after read");
  property p_ovf_holds;
    receive_overflow && !overflow_clear && port_enable |=> receive_overflow;
  endproperty
  a_ovf_holds: assert property (p_ovf_holds)
    else $error("overflow lost");
  property p_ovf_no_ack;
    $rose(receive_overflow) |-> $past(buffer_full) ##0 (!sda_oe) [*8];
  endproperty
  a_ovf_no_ack: assert property (p_ovf_no_ack)
    else $error("ack given on overflow");
  property p_full_acks;
    $rose(buffer_full) && !$past(tx_wr) |-> ##[1:4] sda_oe;
  endproperty
  a_full_acks: assert property (p_full_acks)
    else $error("no ack after load");
  property p_stretch_holds;
    $fell(clock_release) |-> ##[0:8] scl_oe;
  endproperty
  a_stretch_holds: assert property (p_stretch_holds)
    else $error("clock not held");
  property p_release_frees;
    clock_release_set && !update_address |-> ##[1:6] !scl_oe;
  endproperty
  a_release_frees: assert property (p_release_frees)
    else $error("clock not released");
endmodule
bind ssp_i2c_slave ssp_i2c_slave_assertions i_ssp_i2c_slave_assertions (.*);

// File: testbench/ssp_mst.sv
// Behavioural I2C master on an open-drain bus with pull-ups
`timescale 1ns/1ps
module ssp_mst (
  // Clock
  input wire logic ref_clk,
  // Slave pull-down enables
  input wire logic scl_oe,
  input wire logic sda_oe,
  // Bus levels
  output logic scl,
  output logic sda
);
  logic m_scl = 1'b0;
  logic m_sda = 1'b0;
  // Pull-ups win unless some party pulls low
  assign scl = !(scl_oe || m_scl);
  assign sda = !(sda_oe || m_sda);
  // Eight cycles a phase, slower than the slave's minimum
  task automatic q();
    repeat (8) @(negedge ref_clk);
  endtask
  // Let the clock rise, waiting out a stretch by the slave
  task automatic hi();
    m_scl = 1'b0;
    for (int n = 0; n < 4000 && !scl; n++) begin
      @(negedge ref_clk);
    end
    q();
  endtask
  task automatic st();
    m_sda = 1'b0;
    q();
    hi();
    m_sda = 1'b1;
    q();
    m_scl = 1'b1;
    q();
  endtask
  task automatic sp();
    m_sda = 1'b1;
    q();
    hi();
    m_sda = 1'b0;
    q();
  endtask
  // One byte MSB first, then a ninth bit driven as m9
  task automatic xf(input logic [7:0] b, input logic m9,
                    output logic [7:0] r, output logic a);
    for (int i = 8; i >= 0; i--) begin
      m_sda = (i > 0) ? !b[i-1] : !m9;
      q();
      hi();
      if (i > 0) begin
        r[i-1] = sda;
      end else begin
        a = sda;
      end
      m_scl = 1'b1;
      q();
    end
  endtask
endmodule

// File: testbench/tb_top.sv
// Self-checking bench for the serial port slave
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic port_enable = 1'b0;
  logic [3:0] mode_select = 4'h6;
  logic stretch_enable = 1'b0;
  logic pins_are_inputs = 1'b1;
  logic slave_address_wr = 1'b0;
  logic clock_release_set = 1'b0;
  logic overflow_clear = 1'b0;
  logic irq_flag_clear = 1'b0;
  logic tx_wr = 1'b0;
  logic rx_rd = 1'b0;
  logic [7:0] slave_address = 8'h00;
  logic [7:0] tx_data = 8'h00;
  logic [7:0] data_buffer, adr, d, r;
  logic buffer_full, receive_overflow, update_address, read_write;
  logic data_address, start_seen, stop_seen, clock_release, port_irq_flag;
  logic scl_out, scl_oe, sda_out, sda_oe, scl, sda, a;
  logic [3:0] modes [5] = '{4'h8, 4'hb, 4'h0, 4'he, 4'h6};
  int bad_count = 0;
  int checks_done = 0;
  int seed = 52;
  always #2 ref_clk = !ref_clk;
  ssp_i2c_slave i_ssp_i2c_slave (.scl_in(scl), .sda_in(sda), .*);
  ssp_mst i_ssp_mst (.*);
  function automatic logic is_slave(input logic [3:0] m);
    return m == 4'h6 || m == 4'he;
  endfunction
  task automatic chk(input string n, input logic [7:0] e, s);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge ref_clk);
    s = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic ab(input logic [7:0] b);
    i_ssp_mst.st();
    i_ssp_mst.xf(b, 1'b1, r, a);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    give_verdict();
  end
  initial begin
    adr = {7'($random(seed)), 1'b0};
    slave_address = adr;
    repeat (3) @(negedge ref_clk);
    arst_n = 1'b1;
    chk("clock_release", 8'h01, clock_release);
    ab(adr);
    chk("ack", 8'h01, a);
    i_ssp_mst.sp();
    port_enable = 1'b1;
    foreach (modes[i]) begin
      mode_select = modes[i];
      ab(adr);
      chk("ack", {7'h0, !is_slave(modes[i])}, a);
      chk("irq", {7'h0, is_slave(modes[i])}, port_irq_flag);
      i_ssp_mst.sp();
      pulse(rx_rd);
      pulse(irq_flag_clear);
    end
    // Foreign address, then a repeated start to ours
    ab(adr ^ 8'h02);
    chk("ack", 8'h01, a);
    chk("irq", 8'h00, port_irq_flag);
    ab(adr);
    chk("buffer", adr, data_buffer);
    chk("rw", 8'h00, read_write);
    pulse(rx_rd);
    d = 8'($random(seed));
    i_ssp_mst.xf(d, 1'b1, r, a);
    chk("ack", 8'h00, a);
    chk("buffer", d, data_buffer);
    pulse(irq_flag_clear);
    i_ssp_mst.xf(~d, 1'b1, r, a);
    chk("ack", 8'h01, a);
    chk("buffer", d, data_buffer);
    chk("irq", 8'h01, port_irq_flag);
    pulse(rx_rd);
    chk("full", 8'h00, buffer_full);
    chk("overflow", 8'h01, receive_overflow);
    pulse(overflow_clear);
    chk("overflow", 8'h00, receive_overflow);
    stretch_enable = 1'b1;
    ab(adr);
    pulse(rx_rd);
    pulse(clock_release_set);
    i_ssp_mst.xf(d, 1'b1, r, a);
    repeat (8) @(negedge ref_clk);
    chk("clock_release", 8'h00, clock_release);
    chk("scl_oe", 8'h01, scl_oe);
    pulse(rx_rd);
    pulse(clock_release_set);
    repeat (4) @(negedge ref_clk);
    chk("scl_oe", 8'h00, scl_oe);
    i_ssp_mst.sp();
    stretch_enable = 1'b0;
    ab(adr | 8'h01);
    chk("ack", 8'h00, a);
    chk("rw", 8'h01, read_write);
    chk("clock_release", 8'h00, clock_release);
    // Acked byte, then a refused one that ends the read
    for (int k = 0; k < 2; k++) begin
      tx_data = 8'($random(seed));
      pulse(tx_wr);
      pulse(clock_release_set);
      pulse(irq_flag_clear);
      i_ssp_mst.xf(8'hff, k[0], r, a);
      chk("tx", tx_data, r);
      chk("irq", 8'h01, port_irq_flag);
    end
    chk("rw", 8'h00, read_write);
    i_ssp_mst.sp();
    // Ten-bit write of both address bytes, then a re-sent high byte read
    mode_select = 4'h7;
    adr = {5'h1e, 2'($random(seed)), 1'b0};
    d = 8'($random(seed));
    slave_address = adr;
    pulse(rx_rd);
    pulse(irq_flag_clear);
    ab(adr);
    chk("ack", 8'h00, a);
    chk("ua", 8'h01, update_address);
    chk("irq", 8'h01, port_irq_flag);
    slave_address = d;
    pulse(slave_address_wr);
    chk("ua", 8'h00, update_address);
    pulse(rx_rd);
    pulse(irq_flag_clear);
    i_ssp_mst.xf(d, 1'b1, r, a);
    chk("ack", 8'h00, a);
    chk("ua", 8'h01, update_address);
    slave_address = adr;
    pulse(slave_address_wr);
    pulse(rx_rd);
    pulse(irq_flag_clear);
    ab(adr | 8'h01);
    chk("ack", 8'h00, a);
    chk("ua", 8'h00, update_address);
    chk("full", 8'h01, buffer_full);
    chk("irq", 8'h01, port_irq_flag);
    chk("rw", 8'h01, read_write);
    tx_data = 8'($random(seed));
    pulse(tx_wr);
    pulse(clock_release_set);
    pulse(irq_flag_clear);
    i_ssp_mst.xf(8'hff, 1'b1, r, a);
    chk("tx", tx_data, r);
    chk("irq", 8'h01, port_irq_flag);
    i_ssp_mst.sp();
    give_verdict();
  end
endmodule
